// File: hdl/pcs_store.sv
// parameter category store: save, discard and modification-marker control
// assumes dictionary port, object-write report and nonvolatile backend all run on CLK
//
// Overview of operation
// - save key in store subindex starts save
// - finished save writes 1 into that subindex
// - subindex 01 all, 02..06 single categories
// - discard key in restore subindex erases category
// - discard via 01 spares the tuning category
// - erase done triggers automatic restart
// - tuning erased only through restore subindex 06
// - marker saved with save-all on 01
// - savable writes clear marker, except 01 and marker
// - drive category holds only submode select object
// - tuning fixed for objects 2030-2032, 203b, 2050-2052 and 2059
// - reload all saved categories after reset
// - uncategorised objects never stored or restored
`timescale 1ns/1ps
module pcs_store (
	input wire logic CLK,
	input wire logic RST,
	input wire pcs_pkg::pcs_od_req_s OD_REQ, // dictionary access to the three objects
	output logic [33:0] OD_RSP, // pcs_od_rsp_s layout
	input wire logic OBJ_WR, // some other dictionary object was written
	input wire logic [15:0] OBJ_INDEX, // its index
	input wire logic [4:0] OBJ_CAT, // its category mask, zero if uncategorised
	output logic [71:0] NV_CMD, // pcs_nv_cmd_s layout
	input wire logic NV_DONE, // backend finished the pending operation
	input wire pcs_pkg::pcs_mark_s NV_MARK, // marker entries restored by a load
	output logic SAVE_BUSY, // a save is running; motion must stay off
	output logic RESTART // one-cycle restart request after a discard
);
	//////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		pcs_pkg::pcs_state_e state;
		logic [5:0][31:0] save_val; // store subindex contents
		logic [5:0][31:0] disc_val; // restore subindex contents
		logic [2:0] slot; // subindex of the running operation, minus one
		pcs_pkg::pcs_mark_s mark;
		pcs_pkg::pcs_od_rsp_s rsp;
		pcs_pkg::pcs_nv_cmd_s nv;
		logic restart;
		logic busy; // save running, kept as its own flop so the pin comes straight from a register
	} pcs_st_s;

	pcs_st_s st_reg; // registered state
	pcs_st_s st_next; // next state

	//////////////////////////////////////////////////////////////////////////////
	// decoding
	// category mask selected by a trigger subindex; discard-all keeps tuning
	function automatic logic [4:0] sub_mask(input logic [7:0] sub, input logic discard);
		logic [4:0] m;
		m = pcs_pkg::MASK_NONE;
		if (sub == pcs_pkg::SUB_ALL) begin
			m = discard ? pcs_pkg::MASK_FACTORY : pcs_pkg::MASK_ALL;
		end else if (sub > pcs_pkg::SUB_ALL && sub <= pcs_pkg::SUB_COUNT) begin
			m = 5'(5'h01 << (sub - 8'h02));
		end
		return m;
	endfunction : sub_mask

	// category of a written object; fixed objects override the reported class
	function automatic logic [4:0] obj_mask(input logic [15:0] idx, input logic [4:0] cat);
		logic [4:0] m;
		m = cat;
		if (idx == pcs_pkg::IDX_SUBMODE) begin
			m = 5'(1 << pcs_pkg::CAT_DRIVE);
		end else if (idx == pcs_pkg::IDX_POLE || idx == pcs_pkg::IDX_MAXCUR || idx == pcs_pkg::IDX_MAXSPD ||
			idx == pcs_pkg::IDX_OVLD || idx == pcs_pkg::IDX_ENC_ALIGN || idx == pcs_pkg::IDX_ENC_OPT ||
			idx == pcs_pkg::IDX_ENC_RES || idx == pcs_pkg::IDX_ENC_CFG) begin
			m = 5'(1 << pcs_pkg::CAT_TUNE);
		end
		return m;
	endfunction : obj_mask

	// subindex 01..06 of a trigger object
	function automatic logic sub_valid(input logic [7:0] sub);
		return sub >= pcs_pkg::SUB_ALL && sub <= pcs_pkg::SUB_COUNT;
	endfunction : sub_valid

	logic od_save; // access aimed at the store object
	logic od_disc; // access aimed at the restore object
	logic od_mark; // access aimed at the marker object
	logic [2:0] od_slot; // trigger slot addressed

	assign od_save = OD_REQ.index == pcs_pkg::IDX_SAVE;
	assign od_disc = OD_REQ.index == pcs_pkg::IDX_DISCARD;
	assign od_mark = OD_REQ.index == pcs_pkg::IDX_MARKER;
	assign od_slot = 3'(OD_REQ.sub - 8'h01);

	//////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.rsp.ack = 1'b0;
		st_next.rsp.err = 1'b0;
		st_next.restart = 1'b0;
		// marker cleared by any categorised write elsewhere; uncategorised ones leave it
		if (OBJ_WR && obj_mask(OBJ_INDEX, OBJ_CAT) != pcs_pkg::MASK_NONE) begin
			st_next.mark = '0;
		end
		// dictionary access: answered one cycle after the strobe
		if (OD_REQ.wr || OD_REQ.rd) begin
			st_next.rsp.ack = 1'b1;
			st_next.rsp.rdata = pcs_pkg::RESET_VAL;
			if ((od_save || od_disc) && OD_REQ.sub == 8'h00) begin
				st_next.rsp.rdata = 32'(pcs_pkg::SUB_COUNT); // entry count
				st_next.rsp.err = OD_REQ.wr;
			end else if ((od_save || od_disc) && sub_valid(OD_REQ.sub)) begin
				st_next.rsp.rdata = od_save ? st_reg.save_val[od_slot] : st_reg.disc_val[od_slot];
				if (OD_REQ.wr && st_reg.state != pcs_pkg::ST_IDLE) begin
					// a second trigger would race the backend; the host polls instead
					st_next.rsp.err = 1'b1; // refused while an operation runs
				end else if (OD_REQ.wr && od_save) begin
					st_next.save_val[od_slot] = OD_REQ.wdata;
					if (OD_REQ.sub != pcs_pkg::SUB_ALL) begin
						st_next.mark = '0;
					end
					if (OD_REQ.wdata == pcs_pkg::KEY_SAVE) begin
						st_next.state = pcs_pkg::ST_SAVE;
						st_next.slot = od_slot;
						st_next.nv.req = 1'b1;
						st_next.nv.op = pcs_pkg::NV_SAVE;
						st_next.nv.mask = sub_mask(OD_REQ.sub, 1'b0);
						// marker as it stands after this write, so a same-cycle clear counts
						st_next.nv.mark_date = st_next.mark.mark_date;
						st_next.nv.mark_time = st_next.mark.mark_time;
					end
				end else if (OD_REQ.wr) begin
					st_next.disc_val[od_slot] = OD_REQ.wdata;
					if (OD_REQ.wdata == pcs_pkg::KEY_DISCARD) begin
						st_next.state = pcs_pkg::ST_ERASE;
						st_next.slot = od_slot;
						st_next.nv.req = 1'b1;
						st_next.nv.op = pcs_pkg::NV_ERASE;
						// discard-all keeps tuning, which only subindex 06 reaches
						st_next.nv.mask = sub_mask(OD_REQ.sub, 1'b1);
					end
				end
			end else if (od_mark && OD_REQ.sub == 8'h00) begin
				st_next.rsp.rdata = 32'(pcs_pkg::MARK_COUNT);
				st_next.rsp.err = OD_REQ.wr;
			end else if (od_mark && OD_REQ.sub == 8'h01) begin
				st_next.rsp.rdata = st_reg.mark.mark_date;
				if (OD_REQ.wr) begin
					st_next.mark.mark_date = OD_REQ.wdata; // host write wins over a clear
				end
			end else if (od_mark && OD_REQ.sub == 8'h02) begin
				st_next.rsp.rdata = st_reg.mark.mark_time;
				if (OD_REQ.wr) begin
					st_next.mark.mark_time = OD_REQ.wdata;
				end
			end else begin
				st_next.rsp.err = 1'b1; // unmapped object or subindex
			end
		end
		// operation sequencing
		case (st_reg.state)
			pcs_pkg::ST_LOAD: begin
				// reload every saved category straight after reset
				st_next.nv.req = 1'b1;
				st_next.nv.op = pcs_pkg::NV_LOAD;
				st_next.nv.mask = pcs_pkg::MASK_ALL;
				st_next.state = pcs_pkg::ST_LOAD_WAIT;
			end
			pcs_pkg::ST_LOAD_WAIT: begin
				if (NV_DONE) begin
					st_next.nv.req = 1'b0;
					// marker entries return with the saved data; a host write this cycle loses
					st_next.mark = NV_MARK;
					st_next.state = pcs_pkg::ST_IDLE;
				end
			end
			pcs_pkg::ST_SAVE: begin
				if (NV_DONE) begin
					st_next.nv.req = 1'b0;
					// key becomes the completion value that the host polls for
					st_next.save_val[st_reg.slot] = pcs_pkg::SAVE_DONE_VAL;
					st_next.state = pcs_pkg::ST_IDLE;
				end
			end
			pcs_pkg::ST_ERASE: begin
				if (NV_DONE) begin
					// no host command needed: the device restarts and reloads
					st_next.nv.req = 1'b0;
					st_next.restart = 1'b1;
					st_next.state = pcs_pkg::ST_LOAD;
				end
			end
			pcs_pkg::ST_IDLE: begin
				// a backend done pulse while idle is ignored
				st_next.nv.req = st_next.nv.req; // only a keyed write starts work
			end
			default: begin
				st_next.state = pcs_pkg::ST_LOAD;
			end
		endcase
		// busy follows the state being entered, so it rises together with the save request
		st_next.busy = st_next.state == pcs_pkg::ST_SAVE;
	end

	//////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_reg <= '0; // load state has code zero
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs come straight from the state register
	assign OD_RSP = st_reg.rsp;
	assign NV_CMD = st_reg.nv;
	assign SAVE_BUSY = st_reg.busy;
	assign RESTART = st_reg.restart;

	//////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// keyed write in idle launches the save at the next edge
	AST_SAVE_START: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && sub_valid(OD_REQ.sub) &&
		OD_REQ.wdata == pcs_pkg::KEY_SAVE |=> st_reg.nv.req && st_reg.nv.op == pcs_pkg::NV_SAVE && SAVE_BUSY)
		else $error("save key did not start a save");
	AST_SAVE_MASK: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && OD_REQ.sub == 8'h05 &&
		OD_REQ.wdata == pcs_pkg::KEY_SAVE |=> st_reg.nv.mask == 5'h08)
		else $error("drive save selected wrong categories");
	AST_SAVE_DONE: assert property (
		st_reg.state == pcs_pkg::ST_SAVE && NV_DONE |=> st_reg.save_val[st_reg.slot] == 32'h00000001 &&
		!st_reg.nv.req ##1 !SAVE_BUSY)
		else $error("finished save not reported with one");
	AST_DISCARD_ALL: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_disc && OD_REQ.sub == 8'h01 &&
		OD_REQ.wdata == pcs_pkg::KEY_DISCARD |=> st_reg.nv.op == pcs_pkg::NV_ERASE && st_reg.nv.mask == 5'h0f)
		else $error("factory discard touched tuning");
	AST_TUNE_ONLY_06: assert property (
		st_reg.nv.req && st_reg.nv.op == pcs_pkg::NV_ERASE && st_reg.nv.mask[4] |-> st_reg.slot == 3'h5)
		else $error("tuning erased through another subindex");
	// finished erase pulses restart, then the reload begins unasked
	AST_RESTART: assert property (
		st_reg.state == pcs_pkg::ST_ERASE && NV_DONE |=> RESTART ##1 !RESTART && st_reg.nv.req &&
		st_reg.nv.op == pcs_pkg::NV_LOAD)
		else $error("no restart and reload after discard");
	// entering the load wait always asks for every category
	AST_RELOAD: assert property (
		$rose(st_reg.state == pcs_pkg::ST_LOAD_WAIT) |-> st_reg.nv.req && st_reg.nv.mask == 5'h1f)
		else $error("saved data not reloaded");
	AST_MARK_CLEAR: assert property (
		OBJ_WR && OBJ_INDEX == 16'h3202 && !(OD_REQ.wr && od_mark) &&
		!(st_reg.state == pcs_pkg::ST_LOAD_WAIT && NV_DONE) |=> st_reg.mark == '0)
		else $error("marker kept after savable write");
	AST_TUNE_CLEAR: assert property (
		OBJ_WR && OBJ_INDEX == 16'h203b && !(OD_REQ.wr && od_mark) &&
		!(st_reg.state == pcs_pkg::ST_LOAD_WAIT && NV_DONE) |=> st_reg.mark == '0)
		else $error("tuning write left marker set");
	// status-like objects outside every category leave the store alone
	AST_UNCAT: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OBJ_WR && OBJ_CAT == 5'h00 && OBJ_INDEX == 16'h6041 &&
		!OD_REQ.wr |=> $stable(st_reg.mark) && !st_reg.nv.req)
		else $error("uncategorised write changed store state");
	// any other value is kept as data and starts nothing
	AST_BAD_KEY: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && (od_save || od_disc) &&
		OD_REQ.wdata != pcs_pkg::KEY_SAVE && OD_REQ.wdata != pcs_pkg::KEY_DISCARD |=>
		st_reg.state == pcs_pkg::ST_IDLE && !st_reg.nv.req)
		else $error("wrong key started an operation");

	//////////////////////////////////////////////////////////////////////////////
	// marker and per-category checks
	// save-all hands the marker entries of the trigger cycle to the backend
	AST_SAVE_MARK: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && OD_REQ.sub == 8'h01 && !OBJ_WR &&
		OD_REQ.wdata == pcs_pkg::KEY_SAVE |=> st_reg.nv.mark_date == $past(st_reg.mark.mark_date) &&
		st_reg.nv.mark_time == $past(st_reg.mark.mark_time))
		else $error("save-all did not carry the marker");
	// writing store subindex 01 never counts as a change of configuration
	AST_MARK_KEEP: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && OD_REQ.sub == 8'h01 && !OBJ_WR |=>
		$stable(st_reg.mark))
		else $error("store subindex 01 write cleared marker");
	// writing store subindex 02..06 in idle is a change and clears the marker
	AST_MARK_SUBCLR: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && OD_REQ.sub > 8'h01 &&
		OD_REQ.sub <= 8'h06 |=> st_reg.mark == '0)
		else $error("store subindex write kept marker");
	// a drive-category discard touches the submode object only
	AST_ERASE_DRIVE: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_disc && OD_REQ.sub == 8'h05 &&
		OD_REQ.wdata == pcs_pkg::KEY_DISCARD |=> st_reg.nv.op == pcs_pkg::NV_ERASE && st_reg.nv.mask == 5'h08)
		else $error("drive discard selected wrong categories");
	// subindex 06 is the one route to the tuning defaults
	AST_ERASE_TUNE: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_disc && OD_REQ.sub == 8'h06 &&
		OD_REQ.wdata == pcs_pkg::KEY_DISCARD |=> st_reg.nv.op == pcs_pkg::NV_ERASE && st_reg.nv.mask == 5'h10)
		else $error("tuning discard selected wrong categories");
	// a finished load installs the marker entries the backend returned
	AST_LOAD_MARK: assert property (
		st_reg.state == pcs_pkg::ST_LOAD_WAIT && NV_DONE |=> st_reg.mark == $past(NV_MARK) &&
		st_reg.state == pcs_pkg::ST_IDLE)
		else $error("reload did not install the saved marker");
	// a tuning-category save reaches the tuning group only
	AST_SAVE_TUNE: assert property (
		st_reg.state == pcs_pkg::ST_IDLE && OD_REQ.wr && od_save && OD_REQ.sub == 8'h06 &&
		OD_REQ.wdata == pcs_pkg::KEY_SAVE |=> st_reg.nv.mask == 5'h10 && SAVE_BUSY)
		else $error("tuning save selected wrong categories");
endmodule : pcs_store

// File: shared/pcs_pkg.sv
// parameter category store: object indices, keys, category masks, carriers and states
// assumes one device clock; the object dictionary and nonvolatile backend share it
package pcs_pkg;
	//////////////////////////////////////////////////////////////////////////////
	// object indices reached over the dictionary access port
	localparam logic [15:0] IDX_SAVE = 16'h1010; // category_save_trigger
	localparam logic [15:0] IDX_DISCARD = 16'h1011; // category_discard_trigger
	localparam logic [15:0] IDX_MARKER = 16'h1020; // config_modified_marker
	localparam logic [7:0] SUB_COUNT = 8'h06; // highest trigger subindex
	localparam logic [7:0] SUB_ALL = 8'h01; // subindex selecting every category
	localparam logic [7:0] MARK_COUNT = 8'h02; // marker entries: date, time
	// key patterns and completion value
	localparam logic [31:0] KEY_SAVE = 32'h65766173;
	localparam logic [31:0] KEY_DISCARD = 32'h64616f6c;
	localparam logic [31:0] SAVE_DONE_VAL = 32'h00000001;
	localparam logic [31:0] RESET_VAL = 32'h00000000;
	//////////////////////////////////////////////////////////////////////////////
	// category mask bits
	localparam int CAT_COMM = 0;
	localparam int CAT_APP = 1;
	localparam int CAT_CUST = 2;
	localparam int CAT_DRIVE = 3;
	localparam int CAT_TUNE = 4;
	localparam logic [4:0] MASK_NONE = 5'h00;
	localparam logic [4:0] MASK_ALL = 5'h1f;
	localparam logic [4:0] MASK_FACTORY = 5'h0f; // every category but tuning
	// objects with a fixed category
	localparam logic [15:0] IDX_SUBMODE = 16'h3202;
	localparam logic [15:0] IDX_TUNE_LO = 16'h2030;
	localparam logic [15:0] IDX_TUNE_HI = 16'h2059;
	localparam logic [15:0] IDX_POLE = 16'h2030;
	localparam logic [15:0] IDX_MAXCUR = 16'h2031;
	localparam logic [15:0] IDX_MAXSPD = 16'h2032;
	localparam logic [15:0] IDX_OVLD = 16'h203b; // overload_integral_settings
	localparam logic [15:0] IDX_ENC_ALIGN = 16'h2050;
	localparam logic [15:0] IDX_ENC_OPT = 16'h2051;
	localparam logic [15:0] IDX_ENC_RES = 16'h2052;
	localparam logic [15:0] IDX_ENC_CFG = 16'h2059;
	//////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef enum logic [1:0] {NV_LOAD, NV_SAVE, NV_ERASE} pcs_nvop_e;
	typedef enum logic [2:0] {ST_LOAD, ST_LOAD_WAIT, ST_IDLE, ST_SAVE, ST_ERASE} pcs_state_e;
	typedef struct packed {
		logic wr; // write strobe, one cycle
		logic rd; // read strobe, one cycle
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} pcs_od_req_s;
	typedef struct packed {
		logic ack; // one-cycle answer
		logic err; // unmapped or refused
		logic [31:0] rdata;
	} pcs_od_rsp_s;
	typedef struct packed {
		logic req; // held until the backend signals done
		pcs_nvop_e op;
		logic [4:0] mask; // categories touched
		logic [31:0] mark_date; // marker entries to persist on save-all
		logic [31:0] mark_time;
	} pcs_nv_cmd_s;
	typedef struct packed {
		logic [31:0] mark_date;
		logic [31:0] mark_time;
	} pcs_mark_s;
endpackage : pcs_pkg

// File: tb/pcs_nv_model.sv
// pcs_nv_model: behavioural nonvolatile backend facing the store block
// assumes the same clock as the store; answers on the falling edge
`timescale 1ns/1ps
module pcs_nv_model #(
	parameter logic [31:0] MARK_DATE = 32'h11223344, // saved date entry
	parameter logic [31:0] MARK_TIME = 32'h55667788 // saved time entry
) (
	input wire logic CLK,
	input wire logic [71:0] NV_CMD,
	output logic NV_DONE,
	output pcs_pkg::pcs_mark_s NV_MARK
);
	pcs_pkg::pcs_nv_cmd_s cmd; // decoded command
	logic [63:0] mk; // marker bus driven toward the store
	logic slow; // alternates prompt and slow answers
	assign cmd = NV_CMD;
	assign NV_MARK = mk;
	////////////////////////////////////////
	// one operation at a time; the marker bus flips after every answer, so a released bus shows the saved entries or their inverse
	initial begin
		NV_DONE = 1'b0;
		mk = ~{MARK_DATE, MARK_TIME};
		slow = 1'b0;
		forever begin
			@(negedge CLK);
			if (cmd.req === 1'b1) begin
				repeat (slow ? 9 : 1) @(negedge CLK);
				NV_DONE = 1'b1;
				if (cmd.op == pcs_pkg::NV_LOAD) begin
					mk = {MARK_DATE, MARK_TIME};
				end
				@(negedge CLK);
				NV_DONE = 1'b0;
				mk = ~mk;
				slow = ~slow;
			end
		end
	end
endmodule : pcs_nv_model

// File: tb/pcs_store_test.sv
// pcs_store_test: self-checking bench for the parameter category store
// assumes pcs_nv_model stands in for the backend; inputs change on falling edges
`timescale 1ns/1ps
module pcs_store_test;
	localparam logic [31:0] MD = 32'h11223344; // date held in the backend
	localparam logic [31:0] MT = 32'h55667788; // time held in the backend
	localparam logic [15:0] OI [5] = '{16'h3202, 16'h6041, 16'h203b, 16'h6060, 16'h2059}; // reported object writes
	localparam logic [4:0] OC [5] = '{5'h00, 5'h00, 5'h00, 5'h02, 5'h00}; // their categories
	typedef struct packed {logic err; logic [31:0] rd; logic chk;} pcs_exp_s;
	logic clk, rst, obj_wr, save_busy, restart, nv_done;
	logic [15:0] obj_index;
	logic [4:0] obj_cat;
	logic [33:0] od_rsp;
	logic [71:0] nv_cmd;
	pcs_pkg::pcs_od_req_s od_req;
	pcs_pkg::pcs_od_rsp_s rsp;
	pcs_pkg::pcs_nv_cmd_s cmd;
	pcs_pkg::pcs_mark_s nv_mark;
	pcs_exp_s expq[$]; // expected answers, oldest first
	pcs_exp_s e;
	int n_errors, n_checks;
	logic [31:0] seed, d, t, w;
	assign rsp = od_rsp;
	assign cmd = nv_cmd;
	pcs_store u_dut (.CLK(clk), .RST(rst), .OD_REQ(od_req), .OD_RSP(od_rsp), .OBJ_WR(obj_wr),
		.OBJ_INDEX(obj_index), .OBJ_CAT(obj_cat), .NV_CMD(nv_cmd), .NV_DONE(nv_done),
		.NV_MARK(nv_mark), .SAVE_BUSY(save_busy), .RESTART(restart));
	pcs_nv_model #(.MARK_DATE(MD), .MARK_TIME(MT)) u_nv (.CLK(clk), .NV_CMD(nv_cmd),
		.NV_DONE(nv_done), .NV_MARK(nv_mark));
	////////////////////////////////////////
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// xorshift source, fixed start
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// expected category mask per subindex; discard-all spares tuning
	function automatic logic [4:0] msk(int s, bit disc);
		if (s == 1) begin
			return disc ? pcs_pkg::MASK_FACTORY : pcs_pkg::MASK_ALL;
		end
		return 5'(1 << (s - 2));
	endfunction : msk
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		n_checks++;
		if (ex !== got) begin
			$display("mismatch %s expected %h seen %h", nm, ex, got);
			n_errors++;
		end
	endtask : chk
	task automatic finish_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// one dictionary access, entered at a falling edge; the answer is noted first
	task automatic acc(logic wr, logic [15:0] idx, logic [7:0] sub, logic [31:0] wd, logic er,
		logic [31:0] rd, logic c);
		expq.push_back('{er, rd, c});
		od_req = '{wr, !wr, idx, sub, wd};
		@(negedge clk);
		od_req.wr = 1'b0;
		od_req.rd = 1'b0;
		@(negedge clk); // idle cycle, so strobes never drop and rise in one step
	endtask : acc
	// bounded wait: 0 request up, 1 idle, 2 restart pulse
	task automatic wt(int k);
		for (int i = 0; i < 200; i++) begin
			// look first: a prompt backend may already be answering
			if ((k == 0 && cmd.req === 1'b1) || (k == 2 && restart === 1'b1)) return;
			if (k == 1 && cmd.req === 1'b0 && save_busy === 1'b0) return;
			@(negedge clk);
		end
		$display("mismatch wait %0d expected 1 seen 0", k);
		n_errors++;
		finish_test();
	endtask : wt
	////////////////////////////////////////
	// answer watcher: each ack takes the oldest note
	always @(negedge clk) begin
		if (rsp.ack === 1'b1 && expq.size() == 0) begin
			chk("unexpected ack", 0, 1);
		end else if (rsp.ack === 1'b1) begin
			e = expq.pop_front();
			chk("err", 32'(e.err), 32'(rsp.err));
			if (e.chk) begin
				chk("rdata", e.rd, rsp.rdata);
			end
		end
	end
	////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h10;
		rst = 1'b1;
		od_req = '0;
		obj_wr = 1'b0;
		obj_index = '0;
		obj_cat = '0;
		n_errors = 0;
		n_checks = 0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		wt(0);
		chk("load", 32'({pcs_pkg::NV_LOAD, pcs_pkg::MASK_ALL}), 32'({cmd.op, cmd.mask}));
		wt(1);
		acc(0, pcs_pkg::IDX_MARKER, 1, 0, 0, MD, 1);
		acc(0, pcs_pkg::IDX_MARKER, 2, 0, 0, MT, 1);
		acc(0, pcs_pkg::IDX_SAVE, 0, 0, 0, 6, 1);
		acc(0, 16'h1030, 1, 0, 1, 0, 1);
		// wrong keys are kept as values but start nothing
		w = xs() | 32'h80000000;
		acc(1, pcs_pkg::IDX_SAVE, 3, w, 0, 0, 0);
		acc(1, pcs_pkg::IDX_DISCARD, 4, w, 0, 0, 0);
		repeat (3) @(negedge clk);
		chk("req", 0, 32'(cmd.req));
		acc(0, pcs_pkg::IDX_SAVE, 3, 0, 0, w, 1);
		acc(0, pcs_pkg::IDX_MARKER, 1, 0, 0, 0, 1);
		// reported object writes clear the marker only when savable
		for (int i = 0; i < 5; i++) begin
			d = xs();
			acc(1, pcs_pkg::IDX_MARKER, 1, d, 0, 0, 0);
			obj_index = OI[i];
			obj_cat = OC[i];
			obj_wr = 1'b1;
			@(negedge clk);
			obj_wr = 1'b0;
			@(negedge clk);
			acc(0, pcs_pkg::IDX_MARKER, 1, 0, 0, (i == 1) ? d : 0, 1);
		end
		// saves on every subindex, marker carried by save-all
		d = xs();
		t = xs();
		acc(1, pcs_pkg::IDX_MARKER, 1, d, 0, 0, 0);
		acc(1, pcs_pkg::IDX_MARKER, 2, t, 0, 0, 0);
		for (int s = 1; s <= 6; s++) begin
			acc(1, pcs_pkg::IDX_SAVE, 8'(s), pcs_pkg::KEY_SAVE, 0, 0, 0);
			wt(0);
			chk("save", 32'({pcs_pkg::NV_SAVE, msk(s, 0)}), 32'({cmd.op, cmd.mask}));
			chk("busy", 1, 32'(save_busy));
			if (s == 1) begin
				chk("mark date", d, cmd.mark_date);
				chk("mark time", t, cmd.mark_time);
				acc(1, pcs_pkg::IDX_DISCARD, 1, pcs_pkg::KEY_DISCARD, 1, 0, 0);
			end
			wt(1);
			acc(0, pcs_pkg::IDX_SAVE, 8'(s), 0, 0, pcs_pkg::SAVE_DONE_VAL, 1);
			if (s == 1) begin
				acc(0, pcs_pkg::IDX_MARKER, 1, 0, 0, d, 1);
			end
		end
		// discards on every subindex, each followed by restart and reload
		for (int s = 1; s <= 6; s++) begin
			acc(1, pcs_pkg::IDX_DISCARD, 8'(s), pcs_pkg::KEY_DISCARD, 0, 0, 0);
			wt(0);
			chk("erase", 32'({pcs_pkg::NV_ERASE, msk(s, 1)}), 32'({cmd.op, cmd.mask}));
			wt(2);
			wt(0);
			chk("reload", 32'({pcs_pkg::NV_LOAD, pcs_pkg::MASK_ALL}), 32'({cmd.op, cmd.mask}));
			wt(1);
			acc(0, pcs_pkg::IDX_MARKER, 1, 0, 0, MD, 1);
			acc(0, pcs_pkg::IDX_MARKER, 2, 0, 0, MT, 1);
		end
		repeat (2) @(negedge clk);
		chk("pending", 0, 32'(expq.size()));
		finish_test();
	end
endmodule : pcs_store_test
